// >>> hw/csr_pkg.sv
//------------------------------------------------------------
// Purpose: constants for the charger status readback bank
// Assumes: APB slave, 32-bit data, one word per register
// Notes: byte address of a register is four times its index
//------------------------------------------------------------
package csr_pkg;

    //------------------------------------------------------------
    // bus shape
    //------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned SYNC_AGE_W = 2;
    localparam logic [SYNC_AGE_W-1:0] SYNC_SETTLED = 2'h2;

    //------------------------------------------------------------
    // register indices
    //------------------------------------------------------------
    localparam logic [ADDR_W-1:0] IDX_OPT_THERM = 8'h1D;
    localparam logic [ADDR_W-1:0] IDX_PATH_ADC = 8'h1E;
    localparam logic [ADDR_W-1:0] IDX_OTG_TEMP = 8'h1F;
    localparam logic [ADDR_W-1:0] IDX_FAULT_A = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_EVENT_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] IDX_EVENT_MASK = 8'h31;
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h32;

    //------------------------------------------------------------
    // reset values and implemented-bit masks
    //------------------------------------------------------------
    localparam logic [REG_W-1:0] RESET_STATUS = 8'h00;
    localparam logic [REG_W-1:0] RESET_MASK = 8'h00;
    localparam logic [REG_W-1:0] RESET_CONTROL = 8'h00;
    localparam logic [REG_W-1:0] USED_OPT_THERM = 8'hC7;
    localparam logic [REG_W-1:0] USED_PATH_ADC = 8'hFE;
    localparam logic [REG_W-1:0] USED_OTG_TEMP = 8'h1F;
    localparam logic [REG_W-1:0] USED_FAULT_A = 8'hFF;
    localparam logic [REG_W-1:0] USED_CONTROL = 8'h01;

    //------------------------------------------------------------
    // field positions
    //------------------------------------------------------------
    localparam int unsigned OPT_STATE_LSB = 6;
    localparam int unsigned OPT_STATE_MSB = 7;
    localparam int unsigned DIE_HEAT_BIT = 2;
    localparam int unsigned DATALINE_BIT = 1;
    localparam int unsigned BAT_PRESENT_BIT = 0;
    localparam int unsigned FET_TWO_BIT = 7;
    localparam int unsigned FET_ONE_BIT = 6;
    localparam int unsigned ADC_DONE_BIT = 5;
    localparam int unsigned MIN_SYS_BIT = 4;
    localparam int unsigned FAST_TMR_BIT = 3;
    localparam int unsigned TRICKLE_TMR_BIT = 2;
    localparam int unsigned PRE_TMR_BIT = 1;
    localparam int unsigned TOO_LOW_REV_BIT = 4;
    localparam int unsigned COLD_BIT = 3;
    localparam int unsigned COOL_BIT = 2;
    localparam int unsigned WARM_BIT = 1;
    localparam int unsigned HOT_BIT = 0;
    localparam int unsigned CTRL_ONE_SHOT_BIT = 0;

    // index to byte address
    function automatic logic [ADDR_W-1:0] csr_byte_addr(input logic [ADDR_W-1:0] idx);
        return {idx[ADDR_W-3:0], 2'h0};
    endfunction

endpackage

// >>> hw/csr_status_bank.sv
//------------------------------------------------------------
// Purpose: read-only charger status registers plus writable event, mask and control registers behind an APB slave
// Assumes: status inputs are asynchronous to I_CLK
// Notes: zero wait states; events raise a maskable interrupt
//------------------------------------------------------------
// Summary of operation
// RULE1: optimizer state in bits 7-6
// RULE2: bit 2 set during die heat regulation
// RULE3: bit 1 high only while dataline detection
// RULE4: bit 0 set when battery present
// RULE5: fet pair two bit 7, one bit 6
// RULE6: conversion done bit only in one-shot
// RULE7: minimum system bit only in forward mode
// RULE8: per-phase timer expiry bits 3, 2, 1
// RULE9: bit 4 battery too low for reverse
// RULE10: thermistor zones on bits 3 to 0
// RULE11: all status registers reset to zero
// RULE12: host writes never change status values
// RULE13: fault byte of eight read-only bits
// RULE14: fault bits follow active protections
// RULE15: reserved bits read as zero
// RULE16: status bits are live, not latched
`timescale 1ns/1ps
`default_nettype none

module csr_status_bank
    import csr_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [DATA_W-1:0] I_PWDATA,
    output logic [DATA_W-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ,
    input wire logic [1:0] I_OPTIMIZER_STATE,
    input wire logic I_DIE_HEAT_REGULATING,
    input wire logic I_DATALINE_DETECT_RUNNING,
    input wire logic I_ABOVE_BATTERY_LOCKOUT_RELEASE_LEVEL,
    input wire logic I_INPUT_FET_PAIR_TWO_FITTED,
    input wire logic I_INPUT_FET_PAIR_ONE_FITTED,
    input wire logic I_ADC_CONVERSION_DONE,
    input wire logic I_FORWARD_MODE,
    input wire logic I_MIN_SYSTEM_REGULATING,
    input wire logic I_FAST_PHASE_TIMER_EXPIRED,
    input wire logic I_TRICKLE_PHASE_TIMER_EXPIRED,
    input wire logic I_PRE_PHASE_TIMER_EXPIRED,
    input wire logic I_BATTERY_TOO_LOW_REVERSE,
    input wire logic I_THERMISTOR_COLD,
    input wire logic I_THERMISTOR_COOL,
    input wire logic I_THERMISTOR_WARM,
    input wire logic I_THERMISTOR_HOT,
    input wire logic [REG_W-1:0] I_PROTECTION_FAULTS
);

    //------------------------------------------------------------
    // raw register images
    //------------------------------------------------------------
    logic [REG_W-1:0] raw_opt;
    logic [REG_W-1:0] raw_path;
    logic [REG_W-1:0] raw_otg;
    logic [REG_W-1:0] meta_opt_q;
    logic [REG_W-1:0] meta_path_q;
    logic [REG_W-1:0] meta_otg_q;
    logic [REG_W-1:0] meta_fault_q;
    logic [REG_W-1:0] sync_opt_q;
    logic [REG_W-1:0] sync_path_q;
    logic [REG_W-1:0] sync_otg_q;
    logic [REG_W-1:0] sync_fault_q;
    logic [REG_W-1:0] live_opt;
    logic [REG_W-1:0] live_path;
    logic [REG_W-1:0] live_otg;
    logic [REG_W-1:0] live_fault;
    logic [REG_W-1:0] fault_prev_q;
    logic [REG_W-1:0] fault_rise;
    logic [REG_W-1:0] event_q;
    logic [REG_W-1:0] mask_q;
    logic [REG_W-1:0] control_q;
    logic [REG_W-1:0] event_clr;
    logic [DATA_W-1:0] prdata_q;
    logic pslverr_q;
    logic [DATA_W-1:0] rd_data;
    logic rd_hit;
    logic setup_ph;
    logic wr_acc;
    logic one_shot;
    logic [SYNC_AGE_W-1:0] age_q;
    logic settled;
    logic fwd_meta_q;
    logic fwd_sync_q;

    always_comb begin
        raw_opt = RESET_STATUS;
        // RULE1: optimizer code
        raw_opt[OPT_STATE_MSB:OPT_STATE_LSB] = I_OPTIMIZER_STATE;
        // RULE2: die heat flag
        raw_opt[DIE_HEAT_BIT] = I_DIE_HEAT_REGULATING;
        // RULE3: detection running flag
        raw_opt[DATALINE_BIT] = I_DATALINE_DETECT_RUNNING;
        // RULE4: battery present flag
        raw_opt[BAT_PRESENT_BIT] = I_ABOVE_BATTERY_LOCKOUT_RELEASE_LEVEL;
    end

    always_comb begin
        raw_path = RESET_STATUS;
        // RULE5: fet pair placement
        raw_path[FET_TWO_BIT] = I_INPUT_FET_PAIR_TWO_FITTED;
        raw_path[FET_ONE_BIT] = I_INPUT_FET_PAIR_ONE_FITTED;
        raw_path[ADC_DONE_BIT] = I_ADC_CONVERSION_DONE;
        // RULE7: mode gate applied after sync
        raw_path[MIN_SYS_BIT] = I_MIN_SYSTEM_REGULATING;
        // RULE8: phase timer expiry
        raw_path[FAST_TMR_BIT] = I_FAST_PHASE_TIMER_EXPIRED;
        raw_path[TRICKLE_TMR_BIT] = I_TRICKLE_PHASE_TIMER_EXPIRED;
        raw_path[PRE_TMR_BIT] = I_PRE_PHASE_TIMER_EXPIRED;
    end

    always_comb begin
        raw_otg = RESET_STATUS;
        // RULE9: reverse output lockout
        raw_otg[TOO_LOW_REV_BIT] = I_BATTERY_TOO_LOW_REVERSE;
        // RULE10: thermistor zones
        raw_otg[COLD_BIT] = I_THERMISTOR_COLD;
        raw_otg[COOL_BIT] = I_THERMISTOR_COOL;
        raw_otg[WARM_BIT] = I_THERMISTOR_WARM;
        raw_otg[HOT_BIT] = I_THERMISTOR_HOT;
    end

    //------------------------------------------------------------
    // synchronisers
    //------------------------------------------------------------
    // two-bit optimizer code may show one mixed sample on a change
    // RULE11: power-on zeros
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            meta_opt_q <= RESET_STATUS;
            meta_path_q <= RESET_STATUS;
            meta_otg_q <= RESET_STATUS;
            meta_fault_q <= RESET_STATUS;
            sync_opt_q <= RESET_STATUS;
            sync_path_q <= RESET_STATUS;
            sync_otg_q <= RESET_STATUS;
            sync_fault_q <= RESET_STATUS;
            fwd_meta_q <= 1'b0;
            fwd_sync_q <= 1'b0;
        end else begin
            meta_opt_q <= raw_opt;
            meta_path_q <= raw_path;
            meta_otg_q <= raw_otg;
            meta_fault_q <= I_PROTECTION_FAULTS;
            sync_opt_q <= meta_opt_q;
            sync_path_q <= meta_path_q;
            sync_otg_q <= meta_otg_q;
            sync_fault_q <= meta_fault_q;
            fwd_meta_q <= I_FORWARD_MODE;
            fwd_sync_q <= fwd_meta_q;
        end
    end

    // helper for checks: sync pipeline filled
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            age_q <= '0;
        end else if (age_q != SYNC_SETTLED) begin
            age_q <= age_q + 1'b1;
        end
    end

    assign settled = (age_q == SYNC_SETTLED);

    //------------------------------------------------------------
    // live status views
    //------------------------------------------------------------
    assign one_shot = control_q[CTRL_ONE_SHOT_BIT];

    // RULE16: no latching, direct view
    // RULE15: reserved bits masked
    always_comb begin
        live_opt = sync_opt_q & USED_OPT_THERM;
        live_path = sync_path_q & USED_PATH_ADC;
        // RULE6: done only in one-shot mode
        live_path[ADC_DONE_BIT] = sync_path_q[ADC_DONE_BIT] & one_shot;
        // RULE7: gating two raw pins would glitch the flop
        live_path[MIN_SYS_BIT] = sync_path_q[MIN_SYS_BIT] & fwd_sync_q;
        live_otg = sync_otg_q & USED_OTG_TEMP;
        // RULE14: fault bits follow protections
        live_fault = sync_fault_q & USED_FAULT_A;
    end

    //------------------------------------------------------------
    // apb decode
    //------------------------------------------------------------
    assign setup_ph = I_PSEL & ~I_PENABLE;
    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;

    always_comb begin
        rd_data = '0;
        rd_hit = 1'b1;
        if (I_PADDR == csr_byte_addr(IDX_OPT_THERM)) begin
            rd_data[REG_W-1:0] = live_opt;
        end else if (I_PADDR == csr_byte_addr(IDX_PATH_ADC)) begin
            rd_data[REG_W-1:0] = live_path;
        end else if (I_PADDR == csr_byte_addr(IDX_OTG_TEMP)) begin
            rd_data[REG_W-1:0] = live_otg;
        end else if (I_PADDR == csr_byte_addr(IDX_FAULT_A)) begin
            // RULE13: eight-bit fault byte
            rd_data[REG_W-1:0] = live_fault;
        end else if (I_PADDR == csr_byte_addr(IDX_EVENT_STATUS)) begin
            rd_data[REG_W-1:0] = event_q;
        end else if (I_PADDR == csr_byte_addr(IDX_EVENT_MASK)) begin
            rd_data[REG_W-1:0] = mask_q;
        end else if (I_PADDR == csr_byte_addr(IDX_CONTROL)) begin
            rd_data[REG_W-1:0] = control_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // read data captured in setup so the access phase needs no wait
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= I_PWRITE ? '0 : rd_data;
            pslverr_q <= ~rd_hit;
        end else if (I_PSEL & I_PENABLE) begin
            pslverr_q <= 1'b0;
        end
    end

    assign O_PRDATA = prdata_q;
    assign O_PSLVERR = pslverr_q;
    assign O_PREADY = 1'b1;

    //------------------------------------------------------------
    // writable registers
    //------------------------------------------------------------
    // RULE12: status addresses have no write path
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            mask_q <= RESET_MASK;
        end else if (wr_acc && I_PADDR == csr_byte_addr(IDX_EVENT_MASK)) begin
            mask_q <= I_PWDATA[REG_W-1:0];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            control_q <= RESET_CONTROL;
        end else if (wr_acc && I_PADDR == csr_byte_addr(IDX_CONTROL)) begin
            control_q <= I_PWDATA[REG_W-1:0] & USED_CONTROL;
        end
    end

    //------------------------------------------------------------
    // fault events and interrupt
    //------------------------------------------------------------
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            fault_prev_q <= RESET_STATUS;
        end else begin
            fault_prev_q <= live_fault;
        end
    end

    assign fault_rise = live_fault & ~fault_prev_q;
    assign event_clr = (wr_acc && I_PADDR == csr_byte_addr(IDX_EVENT_STATUS)) ?
        I_PWDATA[REG_W-1:0] : '0;

    // a new rise wins over a write-one clear in the same cycle
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            event_q <= RESET_STATUS;
        end else begin
            event_q <= (event_q & ~event_clr) | fault_rise;
        end
    end

    assign O_IRQ = |(event_q & mask_q);

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    AST_OPT_STATE: assert property ( // RULE1
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> live_opt[OPT_STATE_MSB:OPT_STATE_LSB] == $past(I_OPTIMIZER_STATE, 2))
        else $error("optimizer field does not follow input");

    AST_DIE_HEAT: assert property ( // RULE2
        @(posedge I_CLK) disable iff (I_RST)
        (settled && $past(I_DIE_HEAT_REGULATING, 2)) |-> live_opt[DIE_HEAT_BIT])
        else $error("die heat bit missing");

    AST_DATALINE: assert property ( // RULE3
        @(posedge I_CLK) disable iff (I_RST)
        (settled && !$past(I_DATALINE_DETECT_RUNNING, 2)) |-> !live_opt[DATALINE_BIT])
        else $error("detection bit high while idle");

    AST_BAT_PRESENT: assert property ( // RULE4
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> live_opt[BAT_PRESENT_BIT] == $past(I_ABOVE_BATTERY_LOCKOUT_RELEASE_LEVEL, 2))
        else $error("battery present bit wrong");

    AST_FET_PAIRS: assert property ( // RULE5
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> {live_path[FET_TWO_BIT], live_path[FET_ONE_BIT]} ==
            {$past(I_INPUT_FET_PAIR_TWO_FITTED, 2), $past(I_INPUT_FET_PAIR_ONE_FITTED, 2)})
        else $error("fet pair bits swapped or stale");

    AST_ADC_ONE_SHOT: assert property ( // RULE6
        @(posedge I_CLK) disable iff (I_RST)
        (settled && one_shot) |-> live_path[ADC_DONE_BIT] == $past(I_ADC_CONVERSION_DONE, 2))
        else $error("conversion done bit wrong in one-shot mode");

    AST_ADC_CONT: assert property ( // RULE6
        @(posedge I_CLK) disable iff (I_RST)
        !one_shot |-> !live_path[ADC_DONE_BIT])
        else $error("conversion done shown outside one-shot mode");

    AST_MIN_SYS: assert property ( // RULE7
        @(posedge I_CLK) disable iff (I_RST)
        (settled && !$past(I_FORWARD_MODE, 2)) |-> !live_path[MIN_SYS_BIT])
        else $error("minimum system bit set outside forward mode");

    AST_TIMERS: assert property ( // RULE8
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> {live_path[FAST_TMR_BIT], live_path[TRICKLE_TMR_BIT], live_path[PRE_TMR_BIT]} ==
            {$past(I_FAST_PHASE_TIMER_EXPIRED, 2), $past(I_TRICKLE_PHASE_TIMER_EXPIRED, 2),
             $past(I_PRE_PHASE_TIMER_EXPIRED, 2)})
        else $error("timer expiry bits wrong");

    AST_REVERSE_LOW: assert property ( // RULE9
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> live_otg[TOO_LOW_REV_BIT] == $past(I_BATTERY_TOO_LOW_REVERSE, 2))
        else $error("reverse lockout bit wrong");

    AST_THERM_ZONES: assert property ( // RULE10
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> {live_otg[COLD_BIT], live_otg[COOL_BIT], live_otg[WARM_BIT], live_otg[HOT_BIT]} ==
            {$past(I_THERMISTOR_COLD, 2), $past(I_THERMISTOR_COOL, 2),
             $past(I_THERMISTOR_WARM, 2), $past(I_THERMISTOR_HOT, 2)})
        else $error("thermistor zone bits wrong");

    AST_RESET_ZERO: assert property ( // RULE11
        @(posedge I_CLK) disable iff (I_RST)
        (age_q != SYNC_SETTLED) |-> (live_opt == RESET_STATUS && live_path == RESET_STATUS &&
            live_otg == RESET_STATUS && live_fault == RESET_STATUS))
        else $error("status not zero right after reset");

    AST_NO_WRITE: assert property ( // RULE12
        @(posedge I_CLK) disable iff (I_RST)
        (wr_acc && I_PADDR == csr_byte_addr(IDX_FAULT_A) && settled) |=>
            live_fault == $past(I_PROTECTION_FAULTS, 2))
        else $error("write disturbed fault byte");

    AST_FAULT_BYTE: assert property ( // RULE13
        @(posedge I_CLK) disable iff (I_RST)
        (setup_ph && !I_PWRITE && I_PADDR == csr_byte_addr(IDX_FAULT_A)) |=>
            O_PRDATA == {{(DATA_W-REG_W){1'b0}}, $past(live_fault)})
        else $error("fault byte read returned wrong data");

    AST_FAULT_LIVE: assert property ( // RULE14
        @(posedge I_CLK) disable iff (I_RST)
        settled |-> live_fault == $past(I_PROTECTION_FAULTS, 2))
        else $error("fault bits do not follow protections");

    AST_RESERVED: assert property ( // RULE15
        @(posedge I_CLK) disable iff (I_RST)
        ((live_opt & ~USED_OPT_THERM) == '0) && ((live_path & ~USED_PATH_ADC) == '0) &&
            ((live_otg & ~USED_OTG_TEMP) == '0))
        else $error("reserved bit reads nonzero");

    AST_NOT_LATCHED: assert property ( // RULE16
        @(posedge I_CLK) disable iff (I_RST)
        (settled && $past(I_PROTECTION_FAULTS[0], 3) && !$past(I_PROTECTION_FAULTS[0], 2)) |-> !live_fault[0])
        else $error("fault bit held after condition cleared");

    AST_EVENT_SET: assert property (
        @(posedge I_CLK) disable iff (I_RST)
        (|fault_rise) |=> ((event_q & $past(fault_rise)) == $past(fault_rise)))
        else $error("fault rise lost");

endmodule

`default_nettype wire

// >>> dv/tb_charger_status_readback.sv
//------------------------------------------------------------
// Purpose: self-checking bench for the charger status bank
// Assumes: zero-wait APB slave, two-edge status synchroniser
// Notes: expectations come from bench-held input values
//------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_charger_status_readback;
    import csr_pkg::*;

    //------------------------------------------------------------
    // signals
    //------------------------------------------------------------
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [17:0] st = 18'h0;
    logic [7:0] flt = 8'h00;
    logic one_shot = 1'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int errors = 0;
    int total_checks = 0;
    integer seed = 32'hBEE89B90;
    logic [7:0] ridx [4] = '{8'h1D, 8'h1E, 8'h1F, 8'h20};
    logic [31:0] d;
    logic e;
    logic os;

    always #5 clk = ~clk;

    csr_status_bank dut (
        .I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_IRQ(irq),
        .I_OPTIMIZER_STATE(st[1:0]),
        .I_DIE_HEAT_REGULATING(st[2]),
        .I_DATALINE_DETECT_RUNNING(st[3]),
        .I_ABOVE_BATTERY_LOCKOUT_RELEASE_LEVEL(st[4]),
        .I_INPUT_FET_PAIR_TWO_FITTED(st[5]),
        .I_INPUT_FET_PAIR_ONE_FITTED(st[6]),
        .I_ADC_CONVERSION_DONE(st[7]),
        .I_FORWARD_MODE(st[8]),
        .I_MIN_SYSTEM_REGULATING(st[9]),
        .I_FAST_PHASE_TIMER_EXPIRED(st[10]),
        .I_TRICKLE_PHASE_TIMER_EXPIRED(st[11]),
        .I_PRE_PHASE_TIMER_EXPIRED(st[12]),
        .I_BATTERY_TOO_LOW_REVERSE(st[13]),
        .I_THERMISTOR_COLD(st[14]),
        .I_THERMISTOR_COOL(st[15]),
        .I_THERMISTOR_WARM(st[16]),
        .I_THERMISTOR_HOT(st[17]),
        .I_PROTECTION_FAULTS(flt)
    );

    //------------------------------------------------------------
    // expectation and bus tasks
    //------------------------------------------------------------
    function automatic logic [31:0] exp_val(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            8'h1D: v = {st[1:0], 3'h0, st[2], st[3], st[4]};
            8'h1E: v = {st[5], st[6], st[7] & one_shot, st[8] & st[9], st[10], st[11], st[12], 1'h0};
            8'h1F: v = {3'h0, st[13], st[14], st[15], st[16], st[17]};
            8'h20: v = flt;
            default: v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    task automatic finish_test();
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // request held until pready seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] ex, input logic ex_err);
        logic [31:0] r;
        logic er;
        apb(1'h0, idx, 32'h0, r, er);
        `CHK("read data", ex, r)
        `CHK("slave error", ex_err, er)
    endtask

    // sampled mid-cycle, next drive after the rising edge
    task automatic chk_irq(input logic ex);
        @(negedge clk);
        `CHK("interrupt", ex, irq)
        @(posedge clk);
    endtask

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int k = 0; k < 4; k++) rd_chk(ridx[k], 32'h0, 1'h0);
        for (int i = 0; i < 40; i++) begin
            os = (i < 2) ? i[0] : 1'($random(seed));
            apb(1'h1, IDX_CONTROL, {31'h0, os}, d, e);
            one_shot = os;
            st <= (i == 0) ? 18'h3FFFF : (i == 1) ? 18'h0 : 18'($random(seed));
            flt <= (i == 0) ? 8'hFF : 8'($random(seed));
            repeat (3) @(posedge clk);
            rd_chk(ridx[0], exp_val(ridx[0]), 1'h0);
            rd_chk(ridx[1], exp_val(ridx[1]), 1'h0);
            rd_chk(ridx[2], exp_val(ridx[2]), 1'h0);
            rd_chk(ridx[3], exp_val(ridx[3]), 1'h0);
        end
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, ridx[k], ~exp_val(ridx[k]), d, e);
            `CHK("write error", 1'h0, e)
            rd_chk(ridx[k], exp_val(ridx[k]), 1'h0);
        end
        rd_chk(8'h00, 32'h0, 1'h1);
        apb(1'h1, 8'h21, 32'hFFFFFFFF, d, e);
        `CHK("unmapped write error", 1'h1, e)
        rd_chk(8'h21, 32'h0, 1'h1);
        flt <= 8'h00;
        repeat (4) @(posedge clk);
        apb(1'h1, IDX_EVENT_STATUS, 32'hFF, d, e);
        apb(1'h1, IDX_EVENT_MASK, 32'hFF, d, e);
        chk_irq(1'h0);
        flt <= 8'hA5;
        repeat (4) @(posedge clk);
        chk_irq(1'h1);
        rd_chk(IDX_EVENT_STATUS, 32'hA5, 1'h0);
        apb(1'h1, IDX_EVENT_MASK, 32'h00, d, e);
        chk_irq(1'h0);
        apb(1'h1, IDX_EVENT_MASK, 32'h01, d, e);
        chk_irq(1'h1);
        apb(1'h1, IDX_EVENT_STATUS, 32'h01, d, e);
        chk_irq(1'h0);
        rd_chk(IDX_EVENT_STATUS, 32'hA4, 1'h0);
        rd_chk(IDX_FAULT_A, 32'hA5, 1'h0);
        // fault field follows input, event stays
        flt <= 8'h00;
        repeat (3) @(posedge clk);
        rd_chk(IDX_FAULT_A, 32'h0, 1'h0);
        rd_chk(IDX_EVENT_STATUS, 32'hA4, 1'h0);
        finish_test();
    end

endmodule
`default_nettype wire
